/* iom_pkg.sv */
// Constants and types for the I/O port function multiplexer
package iom_pkg;
    localparam int IOM_NPINS = 21;
    localparam int IOM_P1_BASE = 8;
    localparam int IOM_P2_BASE = 16;

    localparam logic [7:0] IOM_ADDR_PORT0_DATA = 8'h80;
    localparam logic [7:0] IOM_ADDR_PORT1_DATA = 8'h90;
    localparam logic [7:0] IOM_ADDR_PORT2_DATA = 8'hA0;
    localparam logic [7:0] IOM_ADDR_PERIPH_LOC = 8'hF1;
    localparam logic [7:0] IOM_ADDR_ANALOG_EN = 8'hF2;
    localparam logic [7:0] IOM_ADDR_PORT0_FSEL = 8'hF3;
    localparam logic [7:0] IOM_ADDR_PORT1_FSEL = 8'hF4;
    localparam logic [7:0] IOM_ADDR_PORT2_FSEL = 8'hF5;
    localparam logic [7:0] IOM_ADDR_PORT0_DIR = 8'hFD;

    localparam logic [7:0] IOM_RST_PORT01_DATA = 8'hFF;
    localparam logic [7:0] IOM_RST_PORT2_DATA = 8'h1F;
    localparam logic [7:0] IOM_RST_ZERO = 8'h00;

    localparam logic [7:0] IOM_MASK_PORT2_DATA = 8'h1F;
    localparam logic [7:0] IOM_MASK_PERIPH_LOC = 8'h73;
    localparam logic [7:0] IOM_MASK_PORT2_FSEL = 8'h7F;

    // Location bits of the peripheral location select register
    localparam int IOM_LOC_TIMER_A = 6;
    localparam int IOM_LOC_TIMER_C = 5;
    localparam int IOM_LOC_TIMER_D = 4;
    localparam int IOM_LOC_SERIAL_B = 1;
    localparam int IOM_LOC_SERIAL_A = 0;

    // Priority and function bits of the port 2 select register
    localparam int IOM_PRI_SERIAL = 6;
    localparam int IOM_PRI_SERB_TIMC = 5;
    localparam int IOM_PRI_TIMA_TIMD = 4;
    localparam int IOM_PRI_SERA_TIMA = 3;
    localparam int IOM_SEL_P2_PIN4 = 2;
    localparam int IOM_SEL_P2_PIN3 = 1;
    localparam int IOM_SEL_P2_PIN0 = 0;

    // Crystal pins and radio test pins
    localparam int IOM_XTAL_PIN_LO = 3;
    localparam int IOM_XTAL_PIN_HI = 4;
    localparam int IOM_RADIO_PIN_BUF = 4;
    localparam int IOM_RADIO_PIN_THR = 5;
    localparam int IOM_RADIO_PIN_SFD = 6;
    localparam int IOM_RADIO_PIN_CCA = 7;

    typedef enum logic [2:0] {
        IOM_OWN_GPIO = 3'h0,
        IOM_OWN_SER_A = 3'h1,
        IOM_OWN_SER_B = 3'h3,
        IOM_OWN_TIM_A = 3'h2,
        IOM_OWN_TIM_C = 3'h6,
        IOM_OWN_TIM_D = 3'h7
    } iom_owner_e;
endpackage

/* iom_pin_cell.sv */
// One pad cell: input synchroniser and registered output controls
`timescale 1ns/1ns
module iom_pin_cell (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pad_in,
    input wire logic out_d,
    input wire logic oe_d,
    input wire logic ana_d,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_ana,
    output logic pad_sync
);
    logic meta_q;
    logic sync_q;
    logic out_q;
    logic oe_q;
    logic ana_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            ana_q <= 1'b0;
        end else begin
            meta_q <= pad_in;
            sync_q <= meta_q;
            out_q <= out_d;
            oe_q <= oe_d;
            ana_q <= ana_d;
        end
    end

    assign pad_out = out_q;
    assign pad_oe = oe_q;
    assign pad_ana = ana_q;
    assign pad_sync = sync_q;
endmodule

/* iom_mux.sv */
// I/O port registers and pin function multiplexer
// Function
// - Four radio status signals can be driven onto port 1 pins 4 to 7.
// - Radio test pins: 4 buffer, 5 threshold, 6 frame delimiter, 7 clear channel.
// - Radio test mode overrides all other settings and forces those pins to output.
// - Port 0 and 1 data are 8 bit, bit-addressable, reset to all ones.
// - Port 2 data holds bits 4..0, reset ones, bits 7..5 read zero.
// - Location bits pick alternative 1 at 0, alternative 2 at 1, per peripheral.
// - Analog enable bit n makes port 0 pin n analog; reset zero.
// - Function select bit 0 gives general I/O, 1 gives peripheral; reset zero.
// - Port 2 select bit 6 picks which serial unit wins port 1 conflicts.
// - Port 2 select bit 5 picks serial B or timer C on port 1.
// - Port 2 select bit 4 picks timer A or timer D on port 1.
// - Port 2 select bit 3 picks serial A or timer A on port 1.
// - Port 0 direction bit: 0 input, 1 output; reset zero.
// - While crystal select is low, its two port 2 pins are analog.
// - The slow crystal uses port 2 pins 3 and 4.
// - Analog enable wins over port 0 function select.
`timescale 1ns/1ns
module iom_mux
    import iom_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_idx,
    input wire logic sfr_bit_val,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic [7:0] port1_gpio_dir,
    input wire logic [4:0] port2_gpio_dir,
    input wire logic slow_crystal_select,
    input wire logic radio_test_out_en,
    input wire logic frame_delimiter_status,
    input wire logic rx_buffer_status,
    input wire logic rx_threshold_status,
    input wire logic channel_clear_status,
    input wire logic [3:0] ser_a_out,
    input wire logic [3:0] ser_a_oe,
    input wire logic [3:0] ser_b_out,
    input wire logic [3:0] ser_b_oe,
    input wire logic [2:0] tim_a_out,
    input wire logic [2:0] tim_a_oe,
    input wire logic [1:0] tim_c_out,
    input wire logic [1:0] tim_c_oe,
    input wire logic [1:0] tim_d_out,
    input wire logic [1:0] tim_d_oe,
    input wire logic [20:0] pin_in,
    output logic [20:0] pin_out,
    output logic [20:0] pin_oe,
    output logic [20:0] pin_analog,
    output logic [20:0] pin_sync
);
    logic [7:0] port0_data_q, port0_data_d;
    logic [7:0] port1_data_q, port1_data_d;
    logic [7:0] port2_data_q, port2_data_d;
    logic [7:0] periph_loc_q, periph_loc_d;
    logic [7:0] analog_en_q, analog_en_d;
    logic [7:0] port0_fsel_q, port0_fsel_d;
    logic [7:0] port1_fsel_q, port1_fsel_d;
    logic [7:0] port2_fsel_q, port2_fsel_d;
    logic [7:0] port0_dir_q, port0_dir_d;
    logic [7:0] rdata_q, rdata_d;
    logic [20:0] out_d, oe_d, ana_d;

    // Byte write, or single-bit write for the bit-addressable port latches
    function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] adr);
        logic [7:0] v;
        v = cur;
        if (sfr_wr && sfr_addr == adr) begin
            v = sfr_wdata;
        end else if (sfr_bit_wr && sfr_addr == adr) begin
            v[sfr_bit_idx] = sfr_bit_val;
        end
        return v;
    endfunction

    function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic [7:0] adr, input logic [7:0] msk);
        return (sfr_wr && sfr_addr == adr) ? (sfr_wdata & msk) : cur;
    endfunction

    always_comb begin
        port0_data_d = upd(port0_data_q, IOM_ADDR_PORT0_DATA);
        port1_data_d = upd(port1_data_q, IOM_ADDR_PORT1_DATA);
        port2_data_d = upd(port2_data_q, IOM_ADDR_PORT2_DATA) & IOM_MASK_PORT2_DATA;
        periph_loc_d = wr_byte(periph_loc_q, IOM_ADDR_PERIPH_LOC, IOM_MASK_PERIPH_LOC);
        analog_en_d = wr_byte(analog_en_q, IOM_ADDR_ANALOG_EN, 8'hFF);
        port0_fsel_d = wr_byte(port0_fsel_q, IOM_ADDR_PORT0_FSEL, 8'hFF);
        port1_fsel_d = wr_byte(port1_fsel_q, IOM_ADDR_PORT1_FSEL, 8'hFF);
        port2_fsel_d = wr_byte(port2_fsel_q, IOM_ADDR_PORT2_FSEL, IOM_MASK_PORT2_FSEL);
        port0_dir_d = wr_byte(port0_dir_q, IOM_ADDR_PORT0_DIR, 8'hFF);
        rdata_d = rdata_q;
        if (sfr_rd) begin
            case (sfr_addr)
                IOM_ADDR_PORT0_DATA: rdata_d = port0_data_q;
                IOM_ADDR_PORT1_DATA: rdata_d = port1_data_q;
                IOM_ADDR_PORT2_DATA: rdata_d = port2_data_q;
                IOM_ADDR_PERIPH_LOC: rdata_d = periph_loc_q;
                IOM_ADDR_ANALOG_EN: rdata_d = analog_en_q;
                IOM_ADDR_PORT0_FSEL: rdata_d = port0_fsel_q;
                IOM_ADDR_PORT1_FSEL: rdata_d = port1_fsel_q;
                IOM_ADDR_PORT2_FSEL: rdata_d = port2_fsel_q;
                IOM_ADDR_PORT0_DIR: rdata_d = port0_dir_q;
                default: rdata_d = IOM_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port0_data_q <= IOM_RST_PORT01_DATA;
            port1_data_q <= IOM_RST_PORT01_DATA;
            port2_data_q <= IOM_RST_PORT2_DATA;
            periph_loc_q <= IOM_RST_ZERO;
            analog_en_q <= IOM_RST_ZERO;
            port0_fsel_q <= IOM_RST_ZERO;
            port1_fsel_q <= IOM_RST_ZERO;
            port2_fsel_q <= IOM_RST_ZERO;
            port0_dir_q <= IOM_RST_ZERO;
            rdata_q <= IOM_RST_ZERO;
        end else begin
            port0_data_q <= port0_data_d;
            port1_data_q <= port1_data_d;
            port2_data_q <= port2_data_d;
            periph_loc_q <= periph_loc_d;
            analog_en_q <= analog_en_d;
            port0_fsel_q <= port0_fsel_d;
            port1_fsel_q <= port1_fsel_d;
            port2_fsel_q <= port2_fsel_d;
            port0_dir_q <= port0_dir_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;

    // Pairwise conflict resolution among the peripherals that claim a pin
    function automatic iom_owner_e resolve(input logic ca, input logic cb, input logic ta, input logic tc,
                                           input logic td, input logic [7:0] pri);
        iom_owner_e w;
        w = IOM_OWN_GPIO;
        if (ca && !(cb && pri[IOM_PRI_SERIAL]) && !(ta && pri[IOM_PRI_SERA_TIMA])) begin
            w = IOM_OWN_SER_A;
        end else if (cb && !(tc && pri[IOM_PRI_SERB_TIMC])) begin
            w = IOM_OWN_SER_B;
        end else if (ta && !(td && pri[IOM_PRI_TIMA_TIMD])) begin
            w = IOM_OWN_TIM_A;
        end else if (tc) begin
            w = IOM_OWN_TIM_C;
        end else if (td) begin
            w = IOM_OWN_TIM_D;
        end
        return w;
    endfunction

    function automatic logic [1:0] drive(input iom_owner_e w, input int k);
        logic [1:0] r;
        r = 2'b00;
        case (w)
            IOM_OWN_SER_A: r = {ser_a_oe[k[1:0]], ser_a_out[k[1:0]]};
            IOM_OWN_SER_B: r = {ser_b_oe[k[1:0]], ser_b_out[k[1:0]]};
            IOM_OWN_TIM_A: r = (k < 3) ? {tim_a_oe[k[1:0]], tim_a_out[k[1:0]]} : 2'b00;
            IOM_OWN_TIM_C: r = {tim_c_oe[k[0]], tim_c_out[k[0]]};
            IOM_OWN_TIM_D: r = {tim_d_oe[k[0]], tim_d_out[k[0]]};
            default: r = 2'b00;
        endcase
        return r;
    endfunction

    always_comb begin
        iom_owner_e w;
        logic [1:0] dv;
        logic [2:0] kk;
        logic ca, cb, ta, tc, td;
        w = IOM_OWN_GPIO;
        dv = 2'b00;
        kk = 3'h0;
        ca = 1'b0;
        cb = 1'b0;
        ta = 1'b0;
        tc = 1'b0;
        td = 1'b0;
        out_d = '0;
        oe_d = '0;
        ana_d = '0;
        // Port 0: fixed order serial A, serial B, timer A
        for (int p = 0; p < 8; p++) begin
            ca = (p >= 2 && p <= 5) && !periph_loc_q[IOM_LOC_SERIAL_A];
            cb = (p >= 2 && p <= 5) && !periph_loc_q[IOM_LOC_SERIAL_B];
            ta = (p >= 2 && p <= 4) && !periph_loc_q[IOM_LOC_TIMER_A];
            w = resolve(ca, cb, ta, 1'b0, 1'b0, IOM_RST_ZERO);
            dv = drive(w, p - 2);
            if (analog_en_q[p]) begin
                ana_d[p] = 1'b1;
            end else if (port0_fsel_q[p]) begin
                out_d[p] = dv[0];
                oe_d[p] = dv[1];
            end else begin
                out_d[p] = port0_data_q[p];
                oe_d[p] = port0_dir_q[p];
            end
        end
        // Port 1: second locations of the serial units and timer A, both timer C locations, first location of timer D
        for (int p = 0; p < 8; p++) begin
            ca = (p >= 2 && p <= 5) && periph_loc_q[IOM_LOC_SERIAL_A];
            cb = (p >= 4) && periph_loc_q[IOM_LOC_SERIAL_B];
            ta = (p <= 2) && periph_loc_q[IOM_LOC_TIMER_A];
            tc = periph_loc_q[IOM_LOC_TIMER_C] ? (p >= 6) : (p == 3 || p == 4);
            td = (p <= 1) && !periph_loc_q[IOM_LOC_TIMER_D];
            w = resolve(ca, cb, ta, tc, td, port2_fsel_q);
            kk = 3'((w == IOM_OWN_SER_A) ? p - 2 : (w == IOM_OWN_SER_B) ? p - 4 : (w == IOM_OWN_TIM_A) ? 2 - p :
                    (w == IOM_OWN_TIM_C) ? p - (periph_loc_q[IOM_LOC_TIMER_C] ? 6 : 3) : p);
            dv = drive(w, int'(kk));
            if (radio_test_out_en && p >= IOM_RADIO_PIN_BUF) begin
                oe_d[IOM_P1_BASE + p] = 1'b1;
            end else if (port1_fsel_q[p]) begin
                out_d[IOM_P1_BASE + p] = dv[0];
                oe_d[IOM_P1_BASE + p] = dv[1];
            end else begin
                out_d[IOM_P1_BASE + p] = port1_data_q[p];
                oe_d[IOM_P1_BASE + p] = port1_gpio_dir[p];
            end
        end
        if (radio_test_out_en) begin
            out_d[IOM_P1_BASE + IOM_RADIO_PIN_BUF] = rx_buffer_status;
            out_d[IOM_P1_BASE + IOM_RADIO_PIN_THR] = rx_threshold_status;
            out_d[IOM_P1_BASE + IOM_RADIO_PIN_SFD] = frame_delimiter_status;
            out_d[IOM_P1_BASE + IOM_RADIO_PIN_CCA] = channel_clear_status;
        end
        // Port 2: timer D second location on pins 0 and 3
        for (int p = 0; p < 5; p++) begin
            out_d[IOM_P2_BASE + p] = port2_data_q[p];
            oe_d[IOM_P2_BASE + p] = port2_gpio_dir[p];
        end
        if (port2_fsel_q[IOM_SEL_P2_PIN0]) begin
            out_d[IOM_P2_BASE] = tim_d_out[0];
            oe_d[IOM_P2_BASE] = tim_d_oe[0] && periph_loc_q[IOM_LOC_TIMER_D];
        end
        if (port2_fsel_q[IOM_SEL_P2_PIN3]) begin
            out_d[IOM_P2_BASE + 3] = tim_d_out[1];
            oe_d[IOM_P2_BASE + 3] = tim_d_oe[1] && periph_loc_q[IOM_LOC_TIMER_D];
        end
        if (port2_fsel_q[IOM_SEL_P2_PIN4]) begin
            out_d[IOM_P2_BASE + 4] = 1'b0;
            oe_d[IOM_P2_BASE + 4] = 1'b0;
        end
        if (!slow_crystal_select) begin
            ana_d[IOM_P2_BASE + IOM_XTAL_PIN_LO] = 1'b1;
            ana_d[IOM_P2_BASE + IOM_XTAL_PIN_HI] = 1'b1;
            oe_d[IOM_P2_BASE + IOM_XTAL_PIN_LO] = 1'b0;
            oe_d[IOM_P2_BASE + IOM_XTAL_PIN_HI] = 1'b0;
            out_d[IOM_P2_BASE + IOM_XTAL_PIN_LO] = 1'b0;
            out_d[IOM_P2_BASE + IOM_XTAL_PIN_HI] = 1'b0;
        end
    end

    for (genvar g = 0; g < IOM_NPINS; g++) begin : g_pin
        iom_pin_cell u_cell (
            .clk(clk),
            .rst_b(rst_b),
            .pad_in(pin_in[g]),
            .out_d(out_d[g]),
            .oe_d(oe_d[g]),
            .ana_d(ana_d[g]),
            .pad_out(pin_out[g]),
            .pad_oe(pin_oe[g]),
            .pad_ana(pin_analog[g]),
            .pad_sync(pin_sync[g])
        );
    end

    property p_radio_force;
        @(posedge clk) disable iff (!rst_b)
        radio_test_out_en |=> (pin_oe[15:12] == 4'hF);
    endproperty
    a_radio_force: assert property (p_radio_force) else $error("radio test pins not forced out");

    property p_radio_map;
        @(posedge clk) disable iff (!rst_b)
        radio_test_out_en |=> (pin_out[12] == $past(rx_buffer_status)) && (pin_out[14] == $past(frame_delimiter_status))
            && (pin_out[15] == $past(channel_clear_status)) && (pin_out[13] == $past(rx_threshold_status));
    endproperty
    a_radio_map: assert property (p_radio_map) else $error("radio status on wrong pin");

    property p_port2_unused;
        @(posedge clk) disable iff (!rst_b)
        (sfr_rd && sfr_addr == IOM_ADDR_PORT2_DATA) |=> (sfr_rdata[7:5] == 3'h0);
    endproperty
    a_port2_unused: assert property (p_port2_unused) else $error("port 2 unused bits not zero");

    property p_bit_write;
        @(posedge clk) disable iff (!rst_b)
        (sfr_bit_wr && !sfr_wr && sfr_addr == IOM_ADDR_PORT0_DATA) ##1 (!sfr_wr && !sfr_bit_wr)
            ##1 (sfr_rd && sfr_addr == IOM_ADDR_PORT0_DATA)
            |=> (sfr_rdata[$past(sfr_bit_idx, 3)] == $past(sfr_bit_val, 3));
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write lost");

    property p_analog_wins;
        @(posedge clk) disable iff (!rst_b)
        analog_en_q[2] |=> pin_analog[2] && !pin_oe[2];
    endproperty
    a_analog_wins: assert property (p_analog_wins) else $error("analog pin not analog");

    property p_dir_out;
        @(posedge clk) disable iff (!rst_b)
        (!analog_en_q[1] && !port0_fsel_q[1] && port0_dir_q[1]) |=> pin_oe[1] && pin_out[1] == $past(port0_data_q[1]);
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("port 0 output not driven");

    property p_xtal;
        @(posedge clk) disable iff (!rst_b)
        !slow_crystal_select |=> pin_analog[19] && pin_analog[20] && !pin_oe[19] && !pin_oe[20];
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal pins not analog");

    property p_sera_tima;
        @(posedge clk) disable iff (!rst_b)
        (port1_fsel_q[2] && periph_loc_q[IOM_LOC_SERIAL_A] && periph_loc_q[IOM_LOC_TIMER_A])
            |=> pin_out[10] == $past(port2_fsel_q[IOM_PRI_SERA_TIMA] ? tim_a_out[0] : ser_a_out[0]);
    endproperty
    a_sera_tima: assert property (p_sera_tima) else $error("serial A versus timer A priority wrong");

    property p_serial_pri;
        @(posedge clk) disable iff (!rst_b)
        (!radio_test_out_en && port1_fsel_q[5] && periph_loc_q[IOM_LOC_SERIAL_A] && periph_loc_q[IOM_LOC_SERIAL_B])
            |=> pin_out[13] == $past(port2_fsel_q[IOM_PRI_SERIAL] ? ser_b_out[1] : ser_a_out[3]);
    endproperty
    a_serial_pri: assert property (p_serial_pri) else $error("serial priority wrong");

    property p_tima_timd;
        @(posedge clk) disable iff (!rst_b)
        (port1_fsel_q[0] && periph_loc_q[IOM_LOC_TIMER_A] && !periph_loc_q[IOM_LOC_TIMER_D])
            |=> pin_out[8] == $past(port2_fsel_q[IOM_PRI_TIMA_TIMD] ? tim_d_out[0] : tim_a_out[2]);
    endproperty
    a_tima_timd: assert property (p_tima_timd) else $error("timer A versus timer D priority wrong");
endmodule

/* iom_testbench.sv */
// Self-checking testbench for the I/O port function multiplexer
`timescale 1ns/1ns
module testbench
    import iom_pkg::*;
;
    typedef struct packed {logic [7:0] addr; logic [7:0] rst; logic [7:0] wdata; logic [7:0] exp;} iom_reg_row_s;
    typedef struct packed {logic [7:0] loc; logic [7:0] pri; logic [4:0] pin; logic val;} iom_pri_row_s;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_bit_wr = 1'b0;
    logic [2:0] sfr_bit_idx = 3'h0;
    logic sfr_bit_val = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic [7:0] port1_gpio_dir = 8'h00;
    logic [4:0] port2_gpio_dir = 5'h00;
    logic slow_crystal_select = 1'b1;
    logic radio_test_out_en = 1'b0;
    logic [3:0] radio_sts = 4'h0;
    logic [3:0] ser_a_out = 4'h0;
    logic [3:0] ser_b_out = 4'hF;
    logic [2:0] tim_a_out = 3'h7;
    logic [1:0] tim_c_out = 2'h2;
    logic [1:0] tim_d_out = 2'h2;
    logic [20:0] pin_in = 21'h0;
    logic [20:0] pin_out;
    logic [20:0] pin_oe;
    logic [20:0] pin_analog;
    logic [20:0] pin_sync;
    logic [7:0] rv;
    int err_count = 0;
    int n_checks = 0;
    // Columns: address, reset value, written value, read-back value
    iom_reg_row_s reg_rows [10] = '{
        '{IOM_ADDR_PORT0_DATA, 8'hFF, 8'h5A, 8'h5A}, '{IOM_ADDR_PORT1_DATA, 8'hFF, 8'hA5, 8'hA5},
        '{IOM_ADDR_PORT2_DATA, 8'h1F, 8'hFF, 8'h1F}, '{IOM_ADDR_PERIPH_LOC, 8'h00, 8'hFF, 8'h73},
        '{IOM_ADDR_ANALOG_EN, 8'h00, 8'h3C, 8'h3C}, '{IOM_ADDR_PORT0_FSEL, 8'h00, 8'hC3, 8'hC3},
        '{IOM_ADDR_PORT1_FSEL, 8'h00, 8'h81, 8'h81}, '{IOM_ADDR_PORT2_FSEL, 8'h00, 8'hFF, 8'h7F},
        '{IOM_ADDR_PORT0_DIR, 8'h00, 8'h96, 8'h96}, '{8'h81, 8'h00, 8'hFF, 8'h00}
    };
    // Columns: location bits, priority bits, pin index, expected level (serial A drives 0, serial B 1)
    iom_pri_row_s pri_rows [10] = '{
        '{8'h00, 8'h00, 5'd3, 1'b0}, '{8'h01, 8'h00, 5'd3, 1'b1},
        '{8'h41, 8'h00, 5'd10, 1'b0}, '{8'h41, 8'h08, 5'd10, 1'b1},
        '{8'h03, 8'h00, 5'd12, 1'b0}, '{8'h03, 8'h40, 5'd12, 1'b1},
        '{8'h22, 8'h00, 5'd14, 1'b1}, '{8'h22, 8'h20, 5'd14, 1'b0},
        '{8'h40, 8'h00, 5'd8, 1'b1}, '{8'h40, 8'h10, 5'd8, 1'b0}
    };

    iom_mux DUT (
        .clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .port1_gpio_dir(port1_gpio_dir), .port2_gpio_dir(port2_gpio_dir),
        .slow_crystal_select(slow_crystal_select), .radio_test_out_en(radio_test_out_en),
        .frame_delimiter_status(radio_sts[2]), .rx_buffer_status(radio_sts[0]),
        .rx_threshold_status(radio_sts[1]), .channel_clear_status(radio_sts[3]),
        .ser_a_out(ser_a_out), .ser_a_oe(4'hF), .ser_b_out(ser_b_out), .ser_b_oe(4'hF),
        .tim_a_out(tim_a_out), .tim_a_oe(3'h7), .tim_c_out(tim_c_out), .tim_c_oe(2'h3),
        .tim_d_out(tim_d_out), .tim_d_oe(2'h3), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_analog(pin_analog), .pin_sync(pin_sync)
    );

    always #20 clk = ~clk;

    task automatic chk(string name, logic [20:0] exp, logic [20:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    task automatic bit_wr(logic [7:0] a, logic [2:0] idx, logic v);
        @(negedge clk);
        sfr_addr = a;
        sfr_bit_idx = idx;
        sfr_bit_val = v;
        sfr_bit_wr = 1'b1;
        @(negedge clk);
        sfr_bit_wr = 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask

    // Register write lands on one edge, the pad controls on the next
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("mismatch watchdog expected finish seen timeout");
        complete_run();
    end

    initial begin
        do_reset();
        foreach (reg_rows[i]) begin
            rd(reg_rows[i].addr, rv);
            chk("reset value", 21'(reg_rows[i].rst), 21'(rv));
            wr(reg_rows[i].addr, reg_rows[i].wdata);
            rd(reg_rows[i].addr, rv);
            chk("read back", 21'(reg_rows[i].exp), 21'(rv));
        end
        do_reset();
        settle();
        chk("pads idle after reset", 21'h0, pin_oe);
        pin_in = 21'h15A5A3;
        bit_wr(IOM_ADDR_PORT0_DATA, 3'h3, 1'b0);
        rd(IOM_ADDR_PORT0_DATA, rv);
        chk("bit write", 21'hF7, 21'(rv));
        wr(IOM_ADDR_PORT0_FSEL, 8'hFF);
        wr(IOM_ADDR_PORT1_FSEL, 8'hFF);
        foreach (pri_rows[i]) begin
            wr(IOM_ADDR_PERIPH_LOC, pri_rows[i].loc);
            wr(IOM_ADDR_PORT2_FSEL, pri_rows[i].pri);
            settle();
            chk("peripheral pin out", 21'(pri_rows[i].val), 21'(pin_out[pri_rows[i].pin]));
            chk("peripheral pin oe", 21'h1, 21'(pin_oe[pri_rows[i].pin]));
        end
        radio_test_out_en = 1'b1;
        for (int k = 0; k < 2; k++) begin
            radio_sts = (k == 0) ? 4'h5 : 4'hA;
            settle();
            chk("radio pin out", 21'(radio_sts), 21'(pin_out[15:12]));
            chk("radio pin oe", 21'hF, 21'(pin_oe[15:12]));
        end
        radio_test_out_en = 1'b0;
        wr(IOM_ADDR_PORT1_FSEL, 8'h00);
        port1_gpio_dir = 8'h01;
        settle();
        chk("port 1 gpio", 21'h3, {19'h0, pin_oe[8], pin_out[8]});
        wr(IOM_ADDR_PERIPH_LOC, 8'h10);
        wr(IOM_ADDR_PORT2_FSEL, 8'h07);
        slow_crystal_select = 1'b0;
        port2_gpio_dir = 5'h18;
        settle();
        chk("crystal pins analog", 21'h3, 21'(pin_analog[20:19]));
        chk("crystal pins not driven", 21'h0, 21'(pin_oe[20:19]));
        chk("port 2 pin 0 peripheral", 21'h2, {19'h0, pin_oe[16], pin_out[16]});
        slow_crystal_select = 1'b1;
        wr(IOM_ADDR_PORT2_FSEL, 8'h00);
        settle();
        chk("crystal pins digital", 21'h0, 21'(pin_analog[20:19]));
        chk("port 2 gpio direction", 21'h3, 21'(pin_oe[20:19]));
        chk("port 2 pin 0 gpio input", 21'h0, 21'(pin_oe[16]));
        wr(IOM_ADDR_PORT0_FSEL, 8'h01);
        wr(IOM_ADDR_ANALOG_EN, 8'h81);
        settle();
        chk("analog enable", 21'h81, 21'(pin_analog[7:0]));
        wr(IOM_ADDR_ANALOG_EN, 8'h00);
        wr(IOM_ADDR_PORT0_FSEL, 8'h00);
        wr(IOM_ADDR_PORT0_DATA, 8'h02);
        wr(IOM_ADDR_PORT0_DIR, 8'h02);
        settle();
        chk("port 0 direction", 21'h02, 21'(pin_oe[7:0]));
        chk("port 0 data out", 21'h1, 21'(pin_out[1]));
        chk("pad input sync", 21'h15A5A3, pin_sync);
        complete_run();
    end
endmodule
